// file: core/ueb_pkg.sv
package ueb_pkg;

   // Data path sizes
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned MAX_PKT    = 64;
   localparam int unsigned ADDR_W     = 6;
   localparam int unsigned CNT_W      = 7;
   localparam int unsigned FIFO_DEPTH = 8;

   // Counter values
   localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 7'h01;
   localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;

   // Link side states
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_TX_SEND = 4'h2,
      ST_TX_WAIT = 4'h4,
      ST_RX      = 4'h8
   } ueb_st_t;

   // Handshake codes toward the serial engine
   typedef enum logic [1:0] {
      HS_NONE  = 2'h0,
      HS_ACK   = 2'h1,
      HS_NAK   = 2'h2,
      HS_STALL = 2'h3
   } ueb_hs_code_t;

   typedef struct packed {
      logic         valid;
      ueb_hs_code_t code;
   } ueb_hs_t;

   // Transmit byte toward the serial engine
   typedef struct packed {
      logic              valid;
      logic              last;
      logic              empty;
      logic [DATA_W-1:0] data;
   } ueb_txb_t;

   // Plain byte with valid
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] data;
   } ueb_byte_t;

   // Firmware command pulses
   typedef struct packed {
      logic set_tx_ready;
      logic clr_tx_ready;
      logic clr_tx_complete;
      logic clr_rx_bank0;
      logic clr_rx_bank1;
      logic set_force_halt;
      logic clr_force_halt;
      logic clr_halt_sent;
      logic ep_reset;
      logic rd;
   } ueb_fw_cmd_t;

   // Link events from the serial engine
   typedef struct packed {
      logic in_token;
      logic out_token;
      logic in_ack;
      logic rx_end;
   } ueb_tok_t;

   // Endpoint control/status view
   typedef struct packed {
      logic             tx_packet_ready;
      logic             tx_complete;
      logic             rx_bank0_full;
      logic             rx_bank1_full;
      logic             halt_handshake_sent;
      logic             force_halt_handshake;
      logic             ep_irq;
      logic [CNT_W-1:0] rx_byte_count;
   } ueb_stat_t;

   // Whole state of the endpoint logic
   typedef struct packed {
      ueb_st_t               st;
      logic                  fw_bank;
      logic                  usb_bank;
      logic [1:0]            tx_rdy;
      logic [1:0][CNT_W-1:0] cnt;
      logic [CNT_W-1:0]      fptr;
      logic [CNT_W-1:0]      uptr;
      logic                  tx_comp;
      logic [1:0]            rx_full;
      logic                  halt_sent;
      logic                  force_halt;
      ueb_hs_t               hs;
      ueb_txb_t              txb;
      ueb_byte_t             rd;
      ueb_stat_t             stat;
   } ueb_state_t;

   localparam ueb_state_t STATE_RST =
      ueb_state_t'({ST_IDLE, {($bits(ueb_state_t) - 4){1'b0}}});

endpackage : ueb_pkg

// file: core/ueb_fifo.sv
module ueb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // Clock, reset, enable, flush
   input  logic             i_core_clk,
   input  logic             i_rst,
   input  logic             i_ce,
   input  logic             i_flush,
   // Fill side
   input  logic             i_valid,
   input  logic [WIDTH-1:0] i_data,
   output logic             o_ready,
   // Drain side
   output logic             o_valid,
   output logic [WIDTH-1:0] o_data,
   input  logic             i_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          ready;
   } ueb_fifo_st_t;

   logic [WIDTH-1:0] mem [DEPTH];
   ueb_fifo_st_t     s;
   ueb_fifo_st_t     n;
   logic             push;
   logic             pop;

   assign push    = i_valid && s.ready;
   assign pop     = o_valid && i_ready;
   assign o_valid = (s.cnt != '0);
   assign o_data  = mem[s.rp];
   assign o_ready = s.ready;

   // Pointer and level update
   always_comb begin
      n = s;
      if (push) n.wp = s.wp + 1'b1;
      if (pop) n.rp = s.rp + 1'b1;
      n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      if (i_flush) begin
         n.wp  = '0;
         n.rp  = '0;
         n.cnt = '0;
      end
      n.ready = (n.cnt != FULL);
   end

   // State register and storage
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s       <= '0;
         s.ready <= 1'b1;
      end else if (i_ce) begin
         s <= n;
         if (push) mem[s.wp] <= i_data;
      end
   end
endmodule : ueb_fifo

// file: core/ueb_bank.sv
module ueb_bank #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 64
) (
   // Clock and enable
   input  logic                     i_core_clk,
   input  logic                     i_ce,
   // Write port
   input  logic                     i_we,
   input  logic [$clog2(DEPTH)-1:0] i_waddr,
   input  logic [WIDTH-1:0]         i_wdata,
   // Read port, combinational
   input  logic [$clog2(DEPTH)-1:0] i_raddr,
   output logic [WIDTH-1:0]         o_rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   assign o_rdata = mem[i_raddr];

   // Byte store
   always_ff @(posedge i_core_clk) begin
      if (i_ce && i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end
endmodule : ueb_bank

// file: core/ueb_top.sv
module ueb_top (
   // Clock, reset, enable
   input  logic                          i_core_clk,
   input  logic                          i_rst,
   input  logic                          i_ce,
   // Endpoint configuration
   input  logic                          i_ping_pong,
   // Firmware side
   input  ueb_pkg::ueb_fw_cmd_t          i_cmd,
   input  logic                          i_fw_wr_valid,
   input  logic [ueb_pkg::DATA_W-1:0]    i_fw_wr_data,
   output logic                          o_fw_wr_ready,
   output ueb_pkg::ueb_byte_t            o_fw_rd,
   output ueb_pkg::ueb_stat_t            o_stat,
   // Link side
   input  ueb_pkg::ueb_tok_t             i_tok,
   input  ueb_pkg::ueb_byte_t            i_rx,
   input  logic                          i_tx_ready,
   output ueb_pkg::ueb_txb_t             o_txb,
   output ueb_pkg::ueb_hs_t              o_hs
);
   ueb_pkg::ueb_state_t                          s;
   ueb_pkg::ueb_state_t                          n;
   logic [1:0]                                   bank_we;
   logic [ueb_pkg::ADDR_W-1:0]                   wr_addr;
   logic [ueb_pkg::DATA_W-1:0]                   wr_data;
   logic [1:0][ueb_pkg::ADDR_W-1:0]              raddr;
   logic [1:0][ueb_pkg::DATA_W-1:0]              rdata;
   logic                                         fifo_valid;
   logic [ueb_pkg::DATA_W-1:0]                   fifo_data;
   logic                                         fifo_take;
   logic                                         fw_busy;
   logic                                         fifo_ready;

   // Firmware write bytes queue here until the firmware bank can take them
   ueb_fifo #(
      .WIDTH (ueb_pkg::DATA_W),
      .DEPTH (ueb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_ce       (i_ce),
      .i_flush    (i_cmd.ep_reset),
      .i_valid    (i_fw_wr_valid),
      .i_data     (i_fw_wr_data),
      .o_ready    (fifo_ready),
      .o_valid    (fifo_valid),
      .o_data     (fifo_data),
      .i_ready    (fifo_take)
   );

   // Two packet banks; single-bank mode uses bank 0 only
   for (genvar b = 0; b < 2; b++) begin : g_bank
      assign raddr[b] = (i_cmd.rd && s.fw_bank == 1'(b)) ?
                        s.fptr[ueb_pkg::ADDR_W-1:0] :
                        s.uptr[ueb_pkg::ADDR_W-1:0];
      ueb_bank #(
         .WIDTH (ueb_pkg::DATA_W),
         .DEPTH (ueb_pkg::MAX_PKT)
      ) u_bank (
         .i_core_clk (i_core_clk),
         .i_ce       (i_ce),
         .i_we       (bank_we[b]),
         .i_waddr    (wr_addr),
         .i_wdata    (wr_data),
         .i_raddr    (raddr[b]),
         .o_rdata    (rdata[b])
      );
   end

   // Firmware commands that move the byte pointer block FIFO draining
   assign fw_busy = i_cmd.set_tx_ready | i_cmd.clr_rx_bank0 |
                    i_cmd.clr_rx_bank1 | i_cmd.rd | i_cmd.ep_reset;

   // Next-state logic: firmware clears first, hardware sets win after, endpoint reset is applied last
   always_comb begin
      n         = s;
      n.hs      = '0;
      n.rd      = '0;
      bank_we   = 2'b00;
      wr_addr   = s.fptr[ueb_pkg::ADDR_W-1:0];
      wr_data   = fifo_data;
      fifo_take = 1'b0;

      // Firmware flag handling
      if (i_cmd.clr_tx_complete) n.tx_comp = 1'b0;
      if (i_cmd.clr_halt_sent) n.halt_sent = 1'b0;
      if (i_cmd.set_force_halt) n.force_halt = 1'b1;
      if (i_cmd.clr_force_halt) n.force_halt = 1'b0;
      if (i_cmd.clr_tx_ready) begin
         n.tx_rdy  = 2'b00;
         n.fw_bank = s.usb_bank;
      end
      if (i_cmd.clr_rx_bank0) begin
         n.rx_full[0] = 1'b0;
         n.fw_bank    = i_ping_pong;
         n.fptr       = ueb_pkg::CNT_ZERO;
      end
      if (i_cmd.clr_rx_bank1) begin
         n.rx_full[1] = 1'b0;
         n.fw_bank    = 1'b0;
         n.fptr       = ueb_pkg::CNT_ZERO;
      end
      if (i_cmd.set_tx_ready) begin
         n.tx_rdy[s.fw_bank] = 1'b1;
         n.cnt[s.fw_bank]    = s.fptr;
         n.fptr              = ueb_pkg::CNT_ZERO;
         if (i_ping_pong) n.fw_bank = ~s.fw_bank;
      end

      // Firmware byte read from its own bank
      if (i_cmd.rd) begin
         n.rd.valid = 1'b1;
         n.rd.data  = rdata[s.fw_bank];
         if (s.fptr < s.cnt[s.fw_bank]) n.fptr = s.fptr + ueb_pkg::CNT_ONE;
      end

      // Drain queued firmware bytes into the firmware bank
      if (fifo_valid && s.st != ueb_pkg::ST_RX && !s.tx_rdy[s.fw_bank] &&
          s.fptr < ueb_pkg::CNT_FULL && !fw_busy) begin
         fifo_take          = 1'b1;
         bank_we[s.fw_bank] = 1'b1;
         n.fptr             = s.fptr + ueb_pkg::CNT_ONE;
      end

      // Link side sequencing
      case (s.st)
         ueb_pkg::ST_IDLE: begin
            if (i_tok.in_token) begin
               if (s.force_halt) begin
                  n.hs.valid  = 1'b1;
                  n.hs.code   = ueb_pkg::HS_STALL;
                  n.halt_sent = 1'b1;
               end else if (!s.tx_rdy[s.usb_bank]) begin
                  n.hs.valid = 1'b1;
                  n.hs.code  = ueb_pkg::HS_NAK;
               end else if (s.cnt[s.usb_bank] == ueb_pkg::CNT_ZERO) begin
                  n.txb.valid = 1'b1;
                  n.txb.last  = 1'b1;
                  n.txb.empty = 1'b1;
                  n.txb.data  = '0;
                  n.st        = ueb_pkg::ST_TX_SEND;
               end else begin
                  n.txb.valid = 1'b1;
                  n.txb.empty = 1'b0;
                  n.txb.data  = rdata[s.usb_bank];
                  n.txb.last  = (s.uptr + ueb_pkg::CNT_ONE ==
                                 s.cnt[s.usb_bank]);
                  n.uptr      = s.uptr + ueb_pkg::CNT_ONE;
                  n.st        = ueb_pkg::ST_TX_SEND;
               end
            end else if (i_tok.out_token) begin
               if (s.force_halt) begin
                  n.hs.valid  = 1'b1;
                  n.hs.code   = ueb_pkg::HS_STALL;
                  n.halt_sent = 1'b1;
               end else if (s.rx_full[s.usb_bank]) begin
                  n.hs.valid = 1'b1;
                  n.hs.code  = ueb_pkg::HS_NAK;
               end else begin
                  n.uptr = ueb_pkg::CNT_ZERO;
                  n.st   = ueb_pkg::ST_RX;
               end
            end
         end
         ueb_pkg::ST_TX_SEND: begin
            if (i_tx_ready) begin
               if (s.txb.last) begin
                  n.txb = '0;
                  n.st  = ueb_pkg::ST_TX_WAIT;
               end else begin
                  n.txb.data = rdata[s.usb_bank];
                  n.txb.last = (s.uptr + ueb_pkg::CNT_ONE ==
                                s.cnt[s.usb_bank]);
                  n.uptr     = s.uptr + ueb_pkg::CNT_ONE;
               end
            end
         end
         ueb_pkg::ST_TX_WAIT: begin
            if (i_tok.in_ack) begin
               n.tx_rdy[s.usb_bank] = 1'b0;
               n.tx_comp            = 1'b1;
               n.usb_bank = i_ping_pong & ~s.usb_bank;
               n.uptr     = ueb_pkg::CNT_ZERO;
               n.st       = ueb_pkg::ST_IDLE;
            end else if (i_tok.in_token || i_tok.out_token) begin
               // No ACK came: keep the bank, host retries later
               n.hs.valid = i_tok.in_token;
               n.hs.code  = ueb_pkg::HS_NAK;
               n.uptr     = ueb_pkg::CNT_ZERO;
               n.st       = ueb_pkg::ST_IDLE;
            end
         end
         ueb_pkg::ST_RX: begin
            if (i_rx.valid && s.uptr < ueb_pkg::CNT_FULL) begin
               bank_we[s.usb_bank] = 1'b1;
               wr_addr = s.uptr[ueb_pkg::ADDR_W-1:0];
               wr_data = i_rx.data;
               n.uptr  = s.uptr + ueb_pkg::CNT_ONE;
            end
            if (i_tok.rx_end) begin
               n.hs.valid            = 1'b1;
               n.hs.code             = ueb_pkg::HS_ACK;
               n.rx_full[s.usb_bank] = 1'b1;
               n.cnt[s.usb_bank]     = s.uptr;
               n.usb_bank = i_ping_pong & ~s.usb_bank;
               n.uptr     = ueb_pkg::CNT_ZERO;
               n.st       = ueb_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = ueb_pkg::ST_IDLE;
         end
      endcase

      // Endpoint reset drops every pointer and held packet
      if (i_cmd.ep_reset) begin
         n.st       = ueb_pkg::ST_IDLE;
         n.fptr     = ueb_pkg::CNT_ZERO;
         n.uptr     = ueb_pkg::CNT_ZERO;
         n.cnt      = '0;
         n.tx_rdy   = 2'b00;
         n.rx_full  = 2'b00;
         n.fw_bank  = 1'b0;
         n.usb_bank = 1'b0;
         n.txb      = '0;
         fifo_take  = 1'b0;
         bank_we    = 2'b00;
      end

      // Status view, registered with the rest
      n.stat.tx_packet_ready      = |n.tx_rdy;
      n.stat.tx_complete          = n.tx_comp;
      n.stat.rx_bank0_full        = n.rx_full[0];
      n.stat.rx_bank1_full        = n.rx_full[1];
      n.stat.halt_handshake_sent  = n.halt_sent;
      n.stat.force_halt_handshake = n.force_halt;
      n.stat.rx_byte_count        = n.cnt[n.fw_bank];
      n.stat.ep_irq = n.tx_comp | (|n.rx_full) | n.halt_sent;
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s <= ueb_pkg::STATE_RST;
      end else if (i_ce) begin
         s <= n;
      end
   end

   // Outputs straight from the state register and the FIFO ready register
   assign o_fw_rd       = s.rd;
   assign o_stat        = s.stat;
   assign o_txb         = s.txb;
   assign o_hs          = s.hs;
   assign o_fw_wr_ready = fifo_ready;

   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   property p_in_nak;
      s.st == ueb_pkg::ST_IDLE && i_tok.in_token && !s.force_halt &&
      !s.tx_rdy[s.usb_bank] && i_ce && !i_cmd.ep_reset
      |=> o_hs.valid && o_hs.code == ueb_pkg::HS_NAK;
   endproperty
   a_in_nak: assert property (p_in_nak)
      else $error("IN with no ready bank not NAKed");

   property p_out_nak;
      s.st == ueb_pkg::ST_IDLE && i_tok.out_token && !s.force_halt &&
      s.rx_full[s.usb_bank] && i_ce && !i_cmd.ep_reset
      |=> o_hs.code == ueb_pkg::HS_NAK && s.st == ueb_pkg::ST_IDLE;
   endproperty
   a_out_nak: assert property (p_out_nak)
      else $error("OUT into busy bank not NAKed");

   property p_tx_comp;
      s.st == ueb_pkg::ST_TX_WAIT && i_tok.in_ack && i_ce &&
      !i_cmd.ep_reset |=> o_stat.tx_complete && o_stat.ep_irq;
   endproperty
   a_tx_comp: assert property (p_tx_comp)
      else $error("ACKed IN did not raise tx_complete");

   property p_comp_cause;
      $rose(s.tx_comp) |-> $past(i_tok.in_ack) &&
      $past(s.st) == ueb_pkg::ST_TX_WAIT;
   endproperty
   a_comp_cause: assert property (p_comp_cause)
      else $error("tx_complete set without host ACK");

   property p_rx_bank0;
      s.st == ueb_pkg::ST_RX && i_tok.rx_end && !s.usb_bank && i_ce &&
      !i_cmd.ep_reset
      |=> o_stat.rx_bank0_full && o_hs.code == ueb_pkg::HS_ACK &&
          o_stat.ep_irq;
   endproperty
   a_rx_bank0: assert property (p_rx_bank0)
      else $error("bank 0 receive not flagged and ACKed");

   property p_pp_swap;
      s.st == ueb_pkg::ST_RX && i_tok.rx_end && i_ping_pong && i_ce &&
      !i_cmd.ep_reset |=> s.usb_bank != $past(s.usb_bank);
   endproperty
   a_pp_swap: assert property (p_pp_swap)
      else $error("ping-pong bank did not swap");

   property p_stall;
      s.st == ueb_pkg::ST_IDLE && (i_tok.in_token || i_tok.out_token) &&
      s.force_halt && i_ce
      |=> o_hs.valid && o_hs.code == ueb_pkg::HS_STALL &&
          o_stat.halt_handshake_sent;
   endproperty
   a_stall: assert property (p_stall)
      else $error("forced halt did not STALL");

   property p_ep_reset;
      i_cmd.ep_reset && i_ce
      |=> s.fptr == '0 && s.uptr == '0 && !o_stat.tx_packet_ready;
   endproperty
   a_ep_reset: assert property (p_ep_reset)
      else $error("endpoint reset left pointers");

   property p_zlp;
      s.st == ueb_pkg::ST_IDLE && i_tok.in_token && !s.force_halt &&
      s.tx_rdy[s.usb_bank] && s.cnt[s.usb_bank] == '0 && i_ce &&
      !i_cmd.ep_reset |=> o_txb.valid && o_txb.empty && o_txb.last;
   endproperty
   a_zlp: assert property (p_zlp)
      else $error("empty bank not sent as zero-length packet");

   property p_bank1_irq;
      o_stat.rx_bank1_full |-> o_stat.ep_irq;
   endproperty
   a_bank1_irq: assert property (p_bank1_irq)
      else $error("rx_bank1_full without interrupt");

   property p_rd_byte;
      i_cmd.rd && i_ce && !i_cmd.ep_reset |=> o_fw_rd.valid;
   endproperty
   a_rd_byte: assert property (p_rd_byte)
      else $error("firmware read gave no byte");

   c_zlp:   cover property (o_txb.valid && o_txb.empty);
   c_stall: cover property (o_hs.code == ueb_pkg::HS_STALL);
   c_both:  cover property (o_stat.rx_bank0_full && o_stat.rx_bank1_full);
   c_comp:  cover property ($rose(o_stat.tx_complete));
endmodule : ueb_top

// file: verification/ueb_host_model.sv
module ueb_host_model (
   // Clock
   input  wire logic               i_core_clk,
   // Toward the endpoint
   output ueb_pkg::ueb_tok_t       o_tok,
   output ueb_pkg::ueb_byte_t      o_rx,
   output logic                    o_tx_ready,
   // From the endpoint
   input  ueb_pkg::ueb_txb_t       i_txb
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 44307;

   // Link idle at time zero
   initial begin
      o_tok      = '0;
      o_rx       = '0;
      o_tx_ready = 1'b0;
   end

   // Serial engine stalls at random while a byte waits
   always @(posedge i_core_clk) begin
      o_tx_ready <= i_txb.valid && ($random(seed) % 3 != 0);
   end

   // One-cycle link event
   task automatic tok(input ueb_pkg::ueb_tok_t t);
      @(posedge i_core_clk);
      o_tok <= t;
      @(posedge i_core_clk);
      o_tok <= '0;
   endtask : tok

   // One received byte; the data line flips once released
   task automatic rx(input logic [7:0] b);
      @(posedge i_core_clk);
      o_rx <= {1'b1, b};
      @(posedge i_core_clk);
      o_rx <= {1'b0, ~b};
   endtask : rx
endmodule : ueb_host_model

// file: verification/ueb_top_tb.sv
module ueb_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [9:0] ueb_w_t;
   localparam ueb_pkg::ueb_tok_t T_IN  = 4'h8;
   localparam ueb_pkg::ueb_tok_t T_OUT = 4'h4;
   localparam ueb_pkg::ueb_tok_t T_ACK = 4'h2;
   localparam ueb_pkg::ueb_tok_t T_END = 4'h1;
   localparam ueb_w_t C_TXRDY = 10'h200, C_CLRRDY = 10'h100;
   localparam ueb_w_t C_CMP = 10'h080, C_CLR0 = 10'h040;
   localparam ueb_w_t C_CLR1 = 10'h020, C_HALT = 10'h010;
   localparam ueb_w_t C_UNHALT = 10'h008, C_CLRSENT = 10'h004;
   localparam ueb_w_t C_EPRST = 10'h002, C_RD = 10'h001;
   logic                 i_core_clk = 1'b0;
   logic                 i_rst = 1'b1;
   logic                 i_ping_pong = 1'b0;
   logic                 i_fw_wr_valid = 1'b0;
   logic [7:0]           i_fw_wr_data = 8'h00;
   ueb_pkg::ueb_fw_cmd_t i_cmd = '0;
   logic                 o_fw_wr_ready, i_tx_ready;
   ueb_pkg::ueb_byte_t   o_fw_rd, i_rx;
   ueb_pkg::ueb_stat_t   o_stat;
   ueb_pkg::ueb_tok_t    i_tok;
   ueb_pkg::ueb_txb_t    o_txb;
   ueb_pkg::ueb_hs_t     o_hs;
   int                   seed = 44307, n_fail = 0, checked = 0, n_acc;
   ueb_w_t               e, hs_q[$], rd_q[$], tx_q[$];
   logic [7:0]           pend[$], pa[$], pb[$], rcv[$];

   always #5 i_core_clk = ~i_core_clk;

   ueb_top uut (.i_core_clk, .i_rst, .i_ce(1'b1), .i_ping_pong, .i_cmd,
      .i_fw_wr_valid, .i_fw_wr_data, .o_fw_wr_ready, .o_fw_rd, .o_stat,
      .i_tok, .i_rx, .i_tx_ready, .o_txb, .o_hs);
   ueb_host_model host (.i_core_clk, .o_tok(i_tok), .o_rx(i_rx),
      .o_tx_ready(i_tx_ready), .i_txb(o_txb));

   task automatic chk(input string nm, input ueb_w_t ex, input ueb_w_t g);
      checked++;
      if (g !== ex) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, ex, g);
      end
   endtask : chk

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   // Pair each result with the oldest note
   always @(posedge i_core_clk) begin
      if (!i_rst && o_hs.valid === 1'b1)
         chk("hs", hs_q.size() ? hs_q.pop_front() : '1, 10'(o_hs.code));
      if (!i_rst && o_fw_rd.valid === 1'b1)
         chk("rd", rd_q.size() ? rd_q.pop_front() : '1, 10'(o_fw_rd.data));
      if (!i_rst && o_txb.valid === 1'b1 && i_tx_ready === 1'b1) begin
         e = tx_q.size() ? tx_q.pop_front() : '1;
         if (e == 10'h200) chk("tx empty", 10'h001, 10'(o_txb.empty));
         else chk("tx", e, {o_txb.empty, o_txb.last, o_txb.data});
      end
   end

   task automatic gap(input int c);
      repeat (c) @(posedge i_core_clk);
      #1;
   endtask : gap

   task automatic cmd(input ueb_w_t c);
      @(posedge i_core_clk);
      i_cmd <= c;
      @(posedge i_core_clk);
      i_cmd <= '0;
      #1;
   endtask : cmd

   // Lets the write FIFO drain before marking the bank ready
   task automatic commit();
      gap(12);
      cmd(C_TXRDY);
   endtask : commit

   task automatic mode(input bit pp);
      @(posedge i_core_clk);
      i_ping_pong <= pp;
      cmd(C_EPRST);
   endtask : mode

   task automatic wr(input int n, input bit strict);
      logic [7:0] b;
      int k;
      n_acc = 0;
      @(posedge i_core_clk);
      for (int i = 0; i < n; i++) begin
         b = 8'($random(seed));
         i_fw_wr_valid <= 1'b1;
         i_fw_wr_data  <= b;
         k = 0;
         do begin
            @(posedge i_core_clk);
            k++;
         end while (o_fw_wr_ready !== 1'b1 && k < 20);
         if (o_fw_wr_ready !== 1'b1) break;
         n_acc++;
         pend.push_back(b);
      end
      i_fw_wr_valid <= 1'b0;
      if (strict) chk("wr", 10'(n), 10'(n_acc));
   endtask : wr

   task automatic in_pkt(input logic [7:0] p[$]);
      int k;
      if (p.size() == 0) tx_q.push_back(10'h200);
      foreach (p[i]) tx_q.push_back({1'b0, i == p.size() - 1, p[i]});
      host.tok(T_IN);
      for (k = 0; k < 400 && tx_q.size() != 0; k++) @(posedge i_core_clk);
      if (tx_q.size() != 0) begin
         n_fail++;
         conclude();
      end
      gap(2);
      chk("cmp early", 0, o_stat.tx_complete);
      host.tok(T_ACK);
      gap(2);
      chk("cmp", 1, o_stat.tx_complete);
      chk("irq", 1, o_stat.ep_irq);
      cmd(C_CMP);
   endtask : in_pkt

   task automatic out_pkt(input int n, input bit ok);
      logic [7:0] b;
      hs_q.push_back(ok ? ueb_pkg::HS_ACK : ueb_pkg::HS_NAK);
      host.tok(T_OUT);
      for (int i = 0; i < n; i++) begin
         b = 8'($random(seed));
         rcv.push_back(b);
         host.rx(b);
      end
      if (ok) host.tok(T_END);
      gap(2);
   endtask : out_pkt

   task automatic rd(input int n);
      repeat (n) begin
         rd_q.push_back(rcv.pop_front());
         cmd(C_RD);
      end
   endtask : rd

   task automatic nak_in();
      hs_q.push_back(ueb_pkg::HS_NAK);
      host.tok(T_IN);
      gap(2);
   endtask : nak_in

   // Main sequence
   initial begin
      repeat (20) @(posedge i_core_clk);
      i_rst <= 1'b0;
      gap(1);
      chk("rst", 0, 10'(o_stat !== '0));
      chk("rst rdy", 1, o_fw_wr_ready);
      nak_in();
      wr(3, 1); pa = pend; pend = {}; commit();
      chk("armed", 1, o_stat.tx_packet_ready);
      in_pkt(pa);
      commit(); in_pkt(pend);
      wr(2, 1); pa = pend; pend = {}; commit();
      wr(9, 0);
      chk("fifo n", 8, 10'(n_acc));
      chk("fifo full", 0, o_fw_wr_ready);
      pb = pend; pend = {};
      in_pkt(pa);
      commit(); in_pkt(pb);
      wr(3, 1); pend = {}; commit(); cmd(C_CLRRDY);
      chk("unarmed", 0, o_stat.tx_packet_ready);
      cmd(C_EPRST); nak_in();
      wr(1, 1); pa = pend; pend = {}; commit(); in_pkt(pa);
      mode(1);
      wr(2, 1); pa = pend; pend = {}; commit();
      wr(3, 1); pb = pend; pend = {};
      in_pkt(pa);
      commit(); in_pkt(pb);
      nak_in();
      mode(0);
      out_pkt(5, 1);
      chk("bk0", 1, o_stat.rx_bank0_full);
      chk("cnt", 5, 10'(o_stat.rx_byte_count));
      out_pkt(0, 0);
      rd(5); cmd(C_CLR0);
      chk("bk0 clr", 0, o_stat.ep_irq);
      out_pkt(64, 1);
      chk("cnt max", 10'h040, 10'(o_stat.rx_byte_count));
      rd(64); cmd(C_CLR0);
      mode(1);
      out_pkt(3, 1); out_pkt(4, 1);
      chk("bk1", 1, o_stat.rx_bank1_full);
      chk("cnt a", 3, 10'(o_stat.rx_byte_count));
      rd(3); cmd(C_CLR0);
      chk("cnt b", 4, 10'(o_stat.rx_byte_count));
      out_pkt(2, 1);
      rd(4); cmd(C_CLR1); rd(2); cmd(C_CLR0);
      chk("rx idle", 0, o_stat.ep_irq);
      cmd(C_HALT);
      chk("halt", 1, o_stat.force_halt_handshake);
      hs_q.push_back(ueb_pkg::HS_STALL); host.tok(T_IN); gap(2);
      chk("sent", 1, o_stat.halt_handshake_sent);
      hs_q.push_back(ueb_pkg::HS_STALL); host.tok(T_OUT); gap(2);
      cmd(C_CLRSENT);
      chk("sent clr", 0, o_stat.ep_irq);
      cmd(C_UNHALT); nak_in();
      chk("left", 0, 10'(hs_q.size() + rd_q.size() + tx_q.size()));
      conclude();
   end
endmodule : ueb_top_tb
